/* test/compare_skip_branch_unit_test.sv */
`timescale 1ns/1ps
`include "csb_map.svh"

module compare_skip_branch_unit_test
	import csb_pkg::*;
;
	// Expected outcome of one accepted operation
	typedef struct packed
	{
		logic taken;
		logic [`CSB_PC_W-1:0] pc;
		logic [`CSB_DATA_W-1:0] st;
		logic [1:0] n;
	} csb_exp_s;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic req_valid_in = 1'b0;
	csb_req_s req_in = '0;
	logic status_register_wr_in = 1'b0;
	logic [`CSB_DATA_W-1:0] status_register_wdata_in = 8'h00;
	logic req_ready_out;
	logic done_out;
	logic taken_out;
	logic [`CSB_PC_W-1:0] pc_next_out;
	logic [`CSB_DATA_W-1:0] status_out;
	int failures = 0; // Mismatch count
	int checks = 0; // Comparison count
	int cyc = 0; // Edge counter for latency
	logic [31:0] seed = 32'h9593ed96; // Xorshift state
	logic [`CSB_DATA_W-1:0] st_m = 8'h00; // Status register model
	csb_exp_s exp_q[$]; // Notes from the driver
	int acc_q[$]; // Accept edges seen

	csb_unit uut
	(
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.req_valid_in(req_valid_in),
		.req_in(req_in),
		.req_ready_out(req_ready_out),
		.status_register_wr_in(status_register_wr_in),
		.status_register_wdata_in(status_register_wdata_in),
		.done_out(done_out),
		.taken_out(taken_out),
		.pc_next_out(pc_next_out),
		.status_out(status_out)
	);

	// Clock at 50 MHz
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Compare and report
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded wait ran out
	task automatic timed_out();
		failures++;
		$display("mismatch handshake expected ready seen stuck");
		wrap_up();
	endtask

	// Reset-state outputs
	task automatic check_reset();
		check("ready", req_ready_out, 1);
		check("done", done_out, 0);
		check("taken", taken_out, 0);
		check("pc_next", pc_next_out, 16'h0000);
		check("status", status_out, 8'h00);
	endtask

	// Whole status register write while idle
	task automatic wr_status(input logic [`CSB_DATA_W-1:0] v);
		req_valid_in = 1'b0;
		status_register_wr_in = 1'b1;
		status_register_wdata_in = v;
		@(negedge clk_in);
		status_register_wr_in = 1'b0;
		st_m = v;
	endtask

	// Note the expectation, present the request, wait for ready again
	task automatic issue(input csb_req_s r, input logic junk);
		csb_exp_s e;
		logic [8:0] d9;
		logic [4:0] d5;
		logic [63:0] j;
		logic cin;
		logic t;
		int k;
		e.st = st_m;
		e.taken = 1'b0;
		e.pc = r.pc + 16'h0001;
		e.n = 2'h1;
		t = 1'b0;
		cin = (r.op == OP_COMPARE_REGS_CARRY) & st_m[`CSB_FLAG_C];
		case (r.op)
			OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE:
			begin
				d9 = {1'b0, r.rd_val} - {1'b0, r.rr_val} - {8'h00, cin};
				d5 = {1'b0, r.rd_val[3:0]} - {1'b0, r.rr_val[3:0]} - {4'h0, cin};
				e.st[`CSB_FLAG_C] = d9[8];
				e.st[`CSB_FLAG_H] = d5[4];
				e.st[`CSB_FLAG_N] = d9[7];
				e.st[`CSB_FLAG_V] = (r.rd_val[7] ^ r.rr_val[7]) & (r.rd_val[7] ^ d9[7]);
				e.st[`CSB_FLAG_Z] = (d9[7:0] == 8'h00) & ((r.op != OP_COMPARE_REGS_CARRY) | st_m[`CSB_FLAG_Z]);
				e.st[`CSB_FLAG_S] = e.st[`CSB_FLAG_N] ^ e.st[`CSB_FLAG_V];
			end
			OP_COMPARE_SKIP_EQUAL: t = (r.rd_val == r.rr_val);
			OP_SKIP_REG_BIT_CLEAR: t = ~r.rd_val[r.bit_sel];
			OP_SKIP_REG_BIT_SET: t = r.rd_val[r.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: t = ~r.io_val[r.bit_sel];
			OP_SKIP_IO_BIT_SET: t = r.io_val[r.bit_sel];
			OP_BRANCH_STATUS_BIT_SET: t = st_m[r.bit_sel];
			OP_BRANCH_STATUS_BIT_CLEAR: t = ~st_m[r.bit_sel];
			OP_BRANCH_EQUAL: t = st_m[`CSB_FLAG_Z];
			OP_BRANCH_NOT_EQUAL: t = ~st_m[`CSB_FLAG_Z];
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: t = st_m[`CSB_FLAG_C];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: t = ~st_m[`CSB_FLAG_C];
			OP_BRANCH_MINUS: t = st_m[`CSB_FLAG_N];
			OP_BRANCH_PLUS: t = ~st_m[`CSB_FLAG_N];
			OP_BRANCH_GREATER_EQUAL: t = ~(st_m[`CSB_FLAG_N] ^ st_m[`CSB_FLAG_V]);
			OP_BRANCH_LESS_THAN: t = st_m[`CSB_FLAG_N] ^ st_m[`CSB_FLAG_V];
			OP_BRANCH_HALF_CARRY_SET: t = st_m[`CSB_FLAG_H];
			OP_BRANCH_HALF_CARRY_CLEAR: t = ~st_m[`CSB_FLAG_H];
			OP_BRANCH_TRANSFER_SET: t = st_m[`CSB_FLAG_T];
			OP_BRANCH_TRANSFER_CLEAR: t = ~st_m[`CSB_FLAG_T];
			OP_BRANCH_OVERFLOW_SET: t = st_m[`CSB_FLAG_V];
			OP_BRANCH_OVERFLOW_CLEAR: t = ~st_m[`CSB_FLAG_V];
			default: t = 1'b0; // Unknown codes step by one
		endcase
		// Skip over one or two words
		if (t && r.op inside {[OP_COMPARE_SKIP_EQUAL:OP_SKIP_IO_BIT_SET]})
		begin
			e.taken = 1'b1;
			e.pc = r.pc + (r.next_two_word ? 16'h0003 : 16'h0002);
			e.n = r.next_two_word ? 2'h3 : 2'h2;
		end
		// Relative branch with sign-extended offset
		if (t && r.op inside {[OP_BRANCH_STATUS_BIT_SET:OP_BRANCH_OVERFLOW_CLEAR]})
		begin
			e.taken = 1'b1;
			e.pc = r.pc + {{9{r.offset[6]}}, r.offset} + 16'h0001;
			e.n = 2'h2;
		end
		st_m = e.st;
		exp_q.push_back(e);
		req_in = r;
		req_valid_in = 1'b1;
		k = 0;
		while (req_ready_out !== 1'b1)
		begin
			@(negedge clk_in);
			k++;
			if (k > 8)
				timed_out();
		end
		@(posedge clk_in);
		@(negedge clk_in);
		k = 0;
		// Requests while busy must be ignored
		while (req_ready_out !== 1'b1)
		begin
			if (junk)
			begin
				j = {rnd(), rnd()};
				req_in = j[55:0];
			end
			k++;
			if (k > 8)
				timed_out();
			@(negedge clk_in);
		end
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	always @(posedge clk_in)
	begin
		csb_exp_s e;
		int a;
		if (rstn_in === 1'b1)
		begin
			if (done_out === 1'b1)
			begin
				if (exp_q.size() == 0 || acc_q.size() == 0)
					check("done_unexpected", done_out, 0);
				else
				begin
					e = exp_q.pop_front();
					a = acc_q.pop_front();
					check("cycles", cyc - a, e.n);
					check("taken", taken_out, e.taken);
					check("pc_next", pc_next_out, e.pc);
					check("status", status_out, e.st);
				end
			end
			if (req_valid_in === 1'b1 && req_ready_out === 1'b1)
				acc_q.push_back(cyc);
		end
		cyc++;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		csb_req_s r;
		logic [31:0] x;
		logic [31:0] y;
		logic [4:0] opv;
		int k;
		repeat (16) @(negedge clk_in);
		check_reset();
		rstn_in = 1'b1;
		@(negedge clk_in);
		repeat (2)
		begin
			for (int i = 0; i < 320; i++)
			begin
				x = rnd();
				y = rnd();
				opv = i[4:0];
				r.op = csb_op_e'(opv);
				r.rd_val = x[7:0];
				r.rr_val = x[8] ? x[7:0] : x[15:8];
				r.bit_sel = x[18:16];
				r.io_val = y[31:24];
				r.offset = (i < 64) ? (i[5] ? 7'h40 : 7'h3f) : y[6:0];
				r.pc = y[22:7];
				r.next_two_word = y[23];
				if (r.op inside {OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET})
					r.rr_val = r.rd_val;
				if (x[31])
					wr_status(x[30:23]);
				issue(r, y[24]);
			end
			req_valid_in = 1'b0;
			k = 0;
			while (exp_q.size() != 0)
			begin
				@(negedge clk_in);
				k++;
				if (k > 8)
					timed_out();
			end
			// Reset in mid-run
			rstn_in = 1'b0;
			@(negedge clk_in);
			check_reset();
			rstn_in = 1'b1;
			st_m = 8'h00;
			acc_q.delete();
			@(negedge clk_in);
		end
		wrap_up();
	end

endmodule

/* verilog/csb_map.svh */
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define CSB_DATA_W 8
`define CSB_PC_W 16
`define CSB_OFS_W 7
`define CSB_BIT_W 3

// ****************************************
// Status register bit positions
// ****************************************
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
`define CSB_FLAG_T 6
`define CSB_FLAG_I 7

// ****************************************
// Reset values
// ****************************************
`define CSB_STATUS_REGISTER_RST 8'h00
`define CSB_PC_RST 16'h0000

// ****************************************
// Cycle counts and program counter steps
// ****************************************
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3
`define CSB_PC_STEP_ONE 16'h0001
`define CSB_PC_STEP_TWO 16'h0002
`define CSB_PC_STEP_THREE 16'h0003

`endif

/* verilog/csb_pkg.sv */
`include "csb_map.svh"

package csb_pkg;

	// ****************************************
	// Operations handled by the unit
	// ****************************************
	typedef enum logic [4:0]
	{
		OP_COMPARE_REGS,
		OP_COMPARE_REGS_CARRY,
		OP_COMPARE_IMMEDIATE,
		OP_COMPARE_SKIP_EQUAL,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_BRANCH_STATUS_BIT_SET,
		OP_BRANCH_STATUS_BIT_CLEAR,
		OP_BRANCH_EQUAL,
		OP_BRANCH_NOT_EQUAL,
		OP_BRANCH_CARRY_SET,
		OP_BRANCH_CARRY_CLEAR,
		OP_BRANCH_SAME_HIGHER,
		OP_BRANCH_LOWER,
		OP_BRANCH_MINUS,
		OP_BRANCH_PLUS,
		OP_BRANCH_GREATER_EQUAL,
		OP_BRANCH_LESS_THAN,
		OP_BRANCH_HALF_CARRY_SET,
		OP_BRANCH_HALF_CARRY_CLEAR,
		OP_BRANCH_TRANSFER_SET,
		OP_BRANCH_TRANSFER_CLEAR,
		OP_BRANCH_OVERFLOW_SET,
		OP_BRANCH_OVERFLOW_CLEAR
	} csb_op_e;

	// ****************************************
	// Request carried into the unit
	// ****************************************
	typedef struct packed
	{
		csb_op_e op;
		logic [`CSB_DATA_W-1:0] rd_val;
		logic [`CSB_DATA_W-1:0] rr_val;
		logic [`CSB_BIT_W-1:0] bit_sel;
		logic [`CSB_DATA_W-1:0] io_val;
		logic [`CSB_OFS_W-1:0] offset;
		logic [`CSB_PC_W-1:0] pc;
		logic next_two_word;
	} csb_req_s;

	// ****************************************
	// Flags from the subtractor
	// ****************************************
	typedef struct packed
	{
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} csb_flags_s;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic
	{
		ST_IDLE,
		ST_BUSY
	} csb_state_e;

endpackage

/* verilog/csb_sub_flags.sv */
`timescale 1ns/1ps
`include "csb_map.svh"

// ****************************************
// Subtract and flag generation
// ****************************************
module csb_sub_flags
	import csb_pkg::*;
(
	// Operands
	input wire logic [`CSB_DATA_W-1:0] a_in,
	input wire logic [`CSB_DATA_W-1:0] b_in,
	// Carry chaining
	input wire logic use_carry_in,
	input wire logic carry_in,
	input wire logic zero_prev_in,
	// Result flags
	output csb_flags_s flags_out
);

	// Borrow taken in only for the carry form
	logic borrow;
	// Difference, never stored by the caller
	logic [`CSB_DATA_W-1:0] diff;
	// Zero of this byte alone
	logic zero_here;

	// Flag equations of a byte subtract
	always_comb
	begin
		borrow = use_carry_in & carry_in;
		diff = a_in - b_in - {7'h00, borrow};
		zero_here = (diff == 8'h00);
		flags_out.h = (~a_in[3] & b_in[3]) | (b_in[3] & diff[3]) | (diff[3] & ~a_in[3]);
		flags_out.c = (~a_in[7] & b_in[7]) | (b_in[7] & diff[7]) | (diff[7] & ~a_in[7]);
		flags_out.v = (a_in[7] & ~b_in[7] & ~diff[7]) | (~a_in[7] & b_in[7] & diff[7]);
		flags_out.n = diff[7];
		flags_out.s = diff[7] ^ flags_out.v;
		// Carry form keeps zero only if the previous byte was zero
		flags_out.z = use_carry_in ? (zero_here & zero_prev_in) : zero_here;
	end

endmodule

/* verilog/csb_unit.sv */
`timescale 1ns/1ps
`include "csb_map.svh"

// What this block does
// - Equal registers skip next instruction, 1/2/3 cycles
// - Compares subtract, set flags, store nothing
// - Register bit zero skips next instruction
// - Register bit one skips next instruction
// - I/O bit zero skips next instruction
// - I/O bit one skips next instruction
// - Generic branch tests status bit s
// - Zero flag selects equal and not-equal branches
// - Carry branches and unsigned aliases follow carry
// - Carry-clear branch uses carry alone, same timing
// - Greater-or-equal taken when N xor V zero
// - Less-than taken when N xor V one
// - Half-carry branches, 1 or 2 cycles
// - Transfer flag branches, relative target
// - Overflow and negative flag branches
// - Skips and branches leave flags untouched
module csb_unit
	import csb_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Request from the core
	input wire logic req_valid_in,
	input csb_req_s req_in,
	output logic req_ready_out,
	// Status register write from other core logic
	input wire logic status_register_wr_in,
	input wire logic [`CSB_DATA_W-1:0] status_register_wdata_in,
	// Results
	output logic done_out,
	output logic taken_out,
	output logic [`CSB_PC_W-1:0] pc_next_out,
	output logic [`CSB_DATA_W-1:0] status_out
);

	// ****************************************
	// State
	// ****************************************
	csb_state_e state_reg, state_next;
	logic [1:0] cnt_reg, cnt_next;
	logic done_reg, done_next;
	logic taken_reg, taken_next;
	logic [`CSB_PC_W-1:0] pc_reg, pc_next;
	logic [`CSB_DATA_W-1:0] status_register_reg, status_register_next;

	// ****************************************
	// Decode signals
	// ****************************************
	// Request taken this cycle
	logic accept;
	// Condition met (skip or branch)
	logic cond;
	// Operation class
	logic is_cmp;
	logic is_skip;
	// Cycles the operation occupies
	logic [1:0] cycles;
	// Target program counter
	logic [`CSB_PC_W-1:0] target;
	// Sign-extended offset
	logic [`CSB_PC_W-1:0] ofs_ext;
	// Selected bits
	logic reg_bit;
	logic io_bit;
	logic status_register_bit;
	// Compare flags
	csb_flags_s cmp_flags;

	// ****************************************
	// Subtractor for compares
	// ****************************************
	csb_sub_flags u_sub
	(
		.a_in(req_in.rd_val),
		.b_in(req_in.rr_val),
		.use_carry_in(req_in.op == OP_COMPARE_REGS_CARRY),
		.carry_in(status_register_reg[`CSB_FLAG_C]),
		.zero_prev_in(status_register_reg[`CSB_FLAG_Z]),
		.flags_out(cmp_flags)
	);

	// Ready whenever no operation is in progress
	assign accept = req_valid_in & (state_reg == ST_IDLE);
	assign req_ready_out = (state_reg == ST_IDLE);

	// ****************************************
	// Condition and target decode
	// ****************************************
	always_comb
	begin
		reg_bit = req_in.rr_val[req_in.bit_sel];
		io_bit = req_in.io_val[req_in.bit_sel];
		status_register_bit = status_register_reg[req_in.bit_sel];
		ofs_ext = {{9{req_in.offset[6]}}, req_in.offset};
		is_cmp = 1'b0;
		is_skip = 1'b0;
		cond = 1'b0;
		case (req_in.op)
			// Compares, no condition
			OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE:
				is_cmp = 1'b1;
			// Skips
			OP_COMPARE_SKIP_EQUAL:
			begin
				is_skip = 1'b1;
				cond = (req_in.rd_val == req_in.rr_val);
			end
			OP_SKIP_REG_BIT_CLEAR:
			begin
				is_skip = 1'b1;
				cond = ~reg_bit;
			end
			OP_SKIP_REG_BIT_SET:
			begin
				is_skip = 1'b1;
				cond = reg_bit;
			end
			OP_SKIP_IO_BIT_CLEAR:
			begin
				is_skip = 1'b1;
				cond = ~io_bit;
			end
			OP_SKIP_IO_BIT_SET:
			begin
				is_skip = 1'b1;
				cond = io_bit;
			end
			// Branches on one status bit
			OP_BRANCH_STATUS_BIT_SET: cond = status_register_bit;
			OP_BRANCH_STATUS_BIT_CLEAR: cond = ~status_register_bit;
			OP_BRANCH_EQUAL: cond = status_register_reg[`CSB_FLAG_Z];
			OP_BRANCH_NOT_EQUAL: cond = ~status_register_reg[`CSB_FLAG_Z];
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: cond = status_register_reg[`CSB_FLAG_C];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER:
				cond = ~status_register_reg[`CSB_FLAG_C];
			OP_BRANCH_MINUS: cond = status_register_reg[`CSB_FLAG_N];
			OP_BRANCH_PLUS: cond = ~status_register_reg[`CSB_FLAG_N];
			// Signed branches from N and V, then H, T and V bit branches
			OP_BRANCH_GREATER_EQUAL:
				cond = ~(status_register_reg[`CSB_FLAG_N] ^ status_register_reg[`CSB_FLAG_V]);
			OP_BRANCH_LESS_THAN:
				cond = status_register_reg[`CSB_FLAG_N] ^ status_register_reg[`CSB_FLAG_V];
			OP_BRANCH_HALF_CARRY_SET: cond = status_register_reg[`CSB_FLAG_H];
			OP_BRANCH_HALF_CARRY_CLEAR: cond = ~status_register_reg[`CSB_FLAG_H];
			OP_BRANCH_TRANSFER_SET: cond = status_register_reg[`CSB_FLAG_T];
			OP_BRANCH_TRANSFER_CLEAR: cond = ~status_register_reg[`CSB_FLAG_T];
			OP_BRANCH_OVERFLOW_SET: cond = status_register_reg[`CSB_FLAG_V];
			OP_BRANCH_OVERFLOW_CLEAR: cond = ~status_register_reg[`CSB_FLAG_V];
			// Unknown code acts as a plain step
			default: cond = 1'b0;
		endcase
		// Cycle count and target
		if (is_cmp || !cond)
		begin
			// Fall through to the next instruction
			cycles = `CSB_CYC_ONE;
			target = req_in.pc + `CSB_PC_STEP_ONE;
		end
		else if (is_skip)
		begin
			// Step over a one or two word instruction
			cycles = req_in.next_two_word ? `CSB_CYC_THREE : `CSB_CYC_TWO;
			target = req_in.pc +
				(req_in.next_two_word ? `CSB_PC_STEP_THREE : `CSB_PC_STEP_TWO);
		end
		else
		begin
			// Relative branch, offset plus one
			cycles = `CSB_CYC_TWO;
			target = req_in.pc + ofs_ext + `CSB_PC_STEP_ONE;
		end
	end

	// ****************************************
	// Sequencer and status next values
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		taken_next = taken_reg;
		pc_next = pc_reg;
		status_register_next = status_register_reg;
		// Software-side write of the whole status register
		if (status_register_wr_in)
			status_register_next = status_register_wdata_in;
		case (state_reg)
			ST_IDLE:
			begin
				if (accept)
				begin
					pc_next = target;
					taken_next = cond;
					// Only compares touch the flags
					if (is_cmp)
					begin
						status_register_next[`CSB_FLAG_C] = cmp_flags.c;
						status_register_next[`CSB_FLAG_Z] = cmp_flags.z;
						status_register_next[`CSB_FLAG_N] = cmp_flags.n;
						status_register_next[`CSB_FLAG_V] = cmp_flags.v;
						status_register_next[`CSB_FLAG_S] = cmp_flags.s;
						status_register_next[`CSB_FLAG_H] = cmp_flags.h;
					end
					// One-cycle operations finish at once
					if (cycles == `CSB_CYC_ONE)
						done_next = 1'b1;
					else
					begin
						state_next = ST_BUSY;
						cnt_next = cycles - `CSB_CYC_ONE;
					end
				end
			end
			ST_BUSY:
			begin
				// Burn the extra cycles of a skip or taken branch
				cnt_next = cnt_reg - `CSB_CYC_ONE;
				if (cnt_reg == `CSB_CYC_ONE)
				begin
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	// Register stage
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 2'h0;
			done_reg <= 1'b0;
			taken_reg <= 1'b0;
			pc_reg <= `CSB_PC_RST;
			status_register_reg <= `CSB_STATUS_REGISTER_RST;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
			taken_reg <= taken_next;
			pc_reg <= pc_next;
			status_register_reg <= status_register_next;
		end
	end

	// Outputs straight from flip-flops
	assign done_out = done_reg;
	assign taken_out = taken_reg;
	assign pc_next_out = pc_reg;
	assign status_out = status_register_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// Two and three cycle completions
	sequence s_done_two;
		!done_out ##1 done_out;
	endsequence
	sequence s_done_three;
		!done_out ##1 !done_out ##1 done_out;
	endsequence

	property p_skip_equal;
		accept && req_in.op == OP_COMPARE_SKIP_EQUAL && req_in.rd_val == req_in.rr_val
			&& !req_in.next_two_word |-> ##1 s_done_two
			##0 pc_next_out == $past(req_in.pc, 2) + 16'h0002;
	endproperty
	a_skip_equal: assert property (p_skip_equal) else $error("equal skip wrong");

	property p_compare_flags;
		accept && req_in.op == OP_COMPARE_REGS && !status_register_wr_in |=> done_out
			&& status_out[1] == ($past(req_in.rd_val) == $past(req_in.rr_val))
			&& status_out[0] == ($past(req_in.rd_val) < $past(req_in.rr_val));
	endproperty
	a_compare_flags: assert property (p_compare_flags) else $error("compare flags wrong");

	property p_reg_clear_skip;
		accept && req_in.op == OP_SKIP_REG_BIT_CLEAR && !reg_bit && req_in.next_two_word
			|-> ##1 s_done_three ##0 pc_next_out == $past(req_in.pc, 3) + 16'h0003;
	endproperty
	a_reg_clear_skip: assert property (p_reg_clear_skip) else $error("reg clear skip wrong");

	property p_reg_set_noskip;
		accept && req_in.op == OP_SKIP_REG_BIT_SET && !reg_bit
			|=> done_out && !taken_out && pc_next_out == $past(req_in.pc) + 16'h0001;
	endproperty
	a_reg_set_noskip: assert property (p_reg_set_noskip) else $error("reg set skip wrong");

	property p_io_clear_skip;
		accept && req_in.op == OP_SKIP_IO_BIT_CLEAR && !io_bit |=> taken_out && !req_ready_out;
	endproperty
	a_io_clear_skip: assert property (p_io_clear_skip) else $error("io clear skip wrong");

	property p_io_set_skip;
		accept && req_in.op == OP_SKIP_IO_BIT_SET && io_bit && !req_in.next_two_word
			|-> ##1 s_done_two ##0 pc_next_out == $past(req_in.pc, 2) + 16'h0002;
	endproperty
	a_io_set_skip: assert property (p_io_set_skip) else $error("io set skip wrong");

	property p_status_branch;
		accept && req_in.op == OP_BRANCH_STATUS_BIT_SET && status_register_bit |-> ##1 s_done_two
			##0 pc_next_out == $past(req_in.pc, 2) + $past(ofs_ext, 2) + 16'h0001;
	endproperty
	a_status_branch: assert property (p_status_branch) else $error("status branch wrong");

	property p_not_equal_fall;
		accept && req_in.op == OP_BRANCH_EQUAL && !status_register_reg[1]
			|=> done_out && !taken_out && pc_next_out == $past(req_in.pc) + 16'h0001;
	endproperty
	a_not_equal_fall: assert property (p_not_equal_fall) else $error("equal branch wrong");

	property p_signed_ge;
		accept && req_in.op == OP_BRANCH_GREATER_EQUAL
			|=> taken_out == !($past(status_register_reg[2]) ^ $past(status_register_reg[3]));
	endproperty
	a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");

	property p_flags_kept;
		accept && !is_cmp && !status_register_wr_in |=> status_out == $past(status_out);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

endmodule
